// ---- inc/dccs_pkg.sv ----
// Constants for the dimmer channel: register map, fields, reset values, tables, timing.
// How it works
// - Curve mode picks linear, log, user or others.
// - Curve settings alter only the output voltage.
// - Gamma mode raises value to exponent 1.00-5.00.
// - Log-exponent mode follows ten to 3(x-1).
// - Breakpoints at fixed values, linear interpolation between.
// - Fixed tables; user curve from registers.
// - Dimming value zero always switches output off.
// - Curve result scaled by channel adjustment factor.
// - Scene recall fades with full-sweep scene time.
// - Sixteen slots: ignore or recall stored value.
// - Learnable slot stores present value on learn.
// - Slumber on/off fade to separate targets.
// - Second slumber ON uses its own time.
// - Second slumber OFF uses its own time.
// - Lock blocks ordinary dimming, slumber, scene commands.
// - Priority switch, step, value work despite lock.
// - Polarity setting picks lock-engaging input value.
// - Lock start: no reaction or fade to value.
// - Lock end: none, value or pre-lock restore.
// - Tracking release applies last command seen locked.
package dccs_pkg;
   localparam logic [7:0] DCCS_CTRL_OFF = 8'h00;
   localparam logic [7:0] DCCS_GAMMA_OFF = 8'h04;
   localparam logic [7:0] DCCS_ADJ_OFF = 8'h08;
   localparam logic [7:0] DCCS_LOCKVAL_OFF = 8'h0c;
   localparam logic [7:0] DCCS_SLUMVAL_OFF = 8'h10;
   localparam logic [7:0] DCCS_TIMEA_OFF = 8'h14;
   localparam logic [7:0] DCCS_TIMEB_OFF = 8'h18;
   localparam logic [7:0] DCCS_TIMEC_OFF = 8'h1c;
   localparam logic [7:0] DCCS_USR0_OFF = 8'h20;
   localparam logic [7:0] DCCS_USR1_OFF = 8'h24;
   localparam logic [7:0] DCCS_USR2_OFF = 8'h28;
   localparam logic [7:0] DCCS_STAT_OFF = 8'h2c;
   localparam logic [7:0] DCCS_SCN_BASE = 8'h40;
   localparam logic [7:0] DCCS_SCN_MASK = 8'hc0;
   localparam int DCCS_MODE_LSB = 0;
   localparam int DCCS_LOCK_EN_BIT = 3;
   localparam int DCCS_LOCK_POL_BIT = 4;
   localparam int DCCS_START_BIT = 5;
   localparam int DCCS_END_LSB = 6;
   localparam int DCCS_SCN_NUM_LSB = 8;
   localparam int DCCS_SCN_EN_BIT = 16;
   localparam int DCCS_SCN_LRN_BIT = 17;
   localparam logic [2:0] DCCS_CURVE_LIN = 3'h0;
   localparam logic [2:0] DCCS_CURVE_LOG = 3'h1;
   localparam logic [2:0] DCCS_CURVE_USER = 3'h2;
   localparam logic [2:0] DCCS_CURVE_GAMMA = 3'h3;
   localparam logic [2:0] DCCS_CURVE_EXP = 3'h4;
   localparam logic [1:0] DCCS_END_NONE = 2'h0;
   localparam logic [1:0] DCCS_END_VALUE = 2'h1;
   localparam logic [1:0] DCCS_END_RESTORE = 2'h2;
   localparam logic [1:0] DCCS_END_TRACK = 2'h3;
   localparam logic [7:0] DCCS_CTRL_RST = 8'h00;
   localparam logic [8:0] DCCS_GAMMA_RST = 9'h040;
   localparam logic [8:0] DCCS_GAMMA_MIN = 9'h040;
   localparam logic [8:0] DCCS_GAMMA_MAX = 9'h140;
   localparam logic [8:0] DCCS_ADJ_RST = 9'h100;
   localparam logic [8:0] DCCS_ONE = 9'h100;
   localparam logic [23:0] DCCS_FULL_STEP = 24'hff0000;
   localparam logic [8:0][7:0] DCCS_LIN_TAB =
      {8'hff, 8'he0, 8'hc0, 8'ha0, 8'h80, 8'h60, 8'h40, 8'h20, 8'h00};
   localparam logic [8:0][7:0] DCCS_LOG_TAB =
      {8'hff, 8'ha3, 8'h64, 8'h3b, 8'h21, 8'h11, 8'h08, 8'h03, 8'h00};
   localparam logic [8:0][7:0] DCCS_EXP_TAB =
      {8'hff, 8'h6c, 8'h2d, 8'h13, 8'h08, 8'h03, 8'h01, 8'h01, 8'h00};
   localparam int DCCS_CLK_HZ = 50000000;
   localparam int DCCS_TICK_MS = 10;
   localparam int DCCS_TICK_CYC = DCCS_CLK_HZ / 1000 * DCCS_TICK_MS;
   localparam int DCCS_TICK_W = 20;
endpackage

// ---- hdl/dccs_top.sv ----
// Dimmer channel: curve mapping, fades, scenes, slumber and lock behind an APB slave.
`timescale 1ns/1ps
`default_nettype none
module dccs_top
   import dccs_pkg::*;
#(
   parameter int TICK_CYC = DCCS_TICK_CYC
)
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sw_stb_i,
   input wire logic sw_val_i,
   input wire logic abs_stb_i,
   input wire logic [7:0] abs_val_i,
   input wire logic scene_stb_i,
   input wire logic [7:0] scene_cmd_i,
   input wire logic slumber_stb_i,
   input wire logic slumber_val_i,
   input wire logic lock_stb_i,
   input wire logic lock_val_i,
   input wire logic prio_sw_stb_i,
   input wire logic prio_sw_val_i,
   input wire logic prio_rel_stb_i,
   input wire logic [3:0] prio_rel_i,
   input wire logic prio_abs_stb_i,
   input wire logic [7:0] prio_abs_val_i,
   output logic [7:0] ctrl_volt_o,
   output logic out_on_o,
   output logic [7:0] dim_value_o,
   output logic locked_o,
   output logic fading_o
);

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [7:0] ctrl;
      logic [8:0] gamma;
      logic [8:0] adj;
      logic [15:0] lockval;
      logic [15:0] slumval;
      logic [31:0] ta;
      logic [31:0] tb;
      logic [31:0] tc;
      logic [8:0][7:0] usr;
      logic [15:0][7:0] scn_val;
      logic [15:0][6:0] scn_num;
      logic [15:0] scn_en;
      logic [15:0] scn_lrn;
      logic [23:0] pos;
      logic [7:0] tgt;
      logic [23:0] step;
      logic fading;
      logic [DCCS_TICK_W-1:0] tick_cnt;
      logic locked;
      logic [7:0] pre;
      logic [7:0] trk;
      logic trk_v;
      logic slp_on2;
      logic slp_off2;
      logic [2:0] gcnt;
      logic [8:0] gx;
      logic [8:0] gpw;
      logic [8:0] gpa;
      logic [8:0] gpb;
      logic [7:0] gam;
      logic [7:0] volt;
      logic on;
   } dccs_state_type;

   dccs_state_type q;
   dccs_state_type n;

   logic wr;
   logic lock_en;
   logic prio_any;
   logic [7:0] dim;
   logic [6:0] snum;
   logic [3:0] si;
   logic [2:0] mode;
   logic [1:0] end_mode;
   logic ord_v;
   logic [7:0] ord_tgt;
   logic [15:0] ord_t;
   logic go;
   logic [7:0] go_tgt;
   logic [15:0] go_t;
   logic tick;
   logic [24:0] up_sum;
   logic [23:0] tgt_w;
   logic [17:0] gprod;
   logic [14:0] gdiff;
   logic [8:0] delta;
   logic [8:0] d9;
   logic [8:0][7:0] tab;
   logic [3:0] bi;
   logic [7:0] p0;
   logic [7:0] p1;
   logic [12:0] ip;
   logic [7:0] cv;
   logic [16:0] adjp;
   logic [8:0] gw;

   assign lock_en = q.ctrl[DCCS_LOCK_EN_BIT];
   assign mode = q.ctrl[DCCS_MODE_LSB +: 3];
   assign end_mode = q.ctrl[DCCS_END_LSB +: 2];
   assign prio_any = lock_en && (prio_sw_stb_i || prio_rel_stb_i || prio_abs_stb_i);
   assign dim = q.pos[23:16];
   assign snum = {1'b0, scene_cmd_i[5:0]} + 7'h01;
   assign si = paddr_i[5:2];
   assign wr = psel_i && penable_i && pwrite_i && q.pready && !q.pslverr;
   assign tick = (q.tick_cnt == DCCS_TICK_W'(TICK_CYC - 1));
   assign tgt_w = {q.tgt, 16'h0000};
   assign up_sum = {1'b0, q.pos} + {1'b0, q.step};
   assign gprod = q.gpw * q.gx;
   assign gdiff = (q.gpa - q.gpb) * q.gamma[5:0];
   assign d9 = {1'b0, dim};
   assign delta = DCCS_ONE >> (prio_rel_i[2:0] - 3'h1);
   assign gw = pwdata_i[8:0];

   // ----------------------------------------------------------------
   // Curve evaluation
   // ----------------------------------------------------------------
   always_comb
   begin
      tab = DCCS_LIN_TAB;
      if (mode == DCCS_CURVE_LOG)
         tab = DCCS_LOG_TAB;
      else if (mode == DCCS_CURVE_USER)
         tab = q.usr;
      else if (mode == DCCS_CURVE_EXP)
         tab = DCCS_EXP_TAB;
      bi = {1'b0, dim[7:5]};
      p0 = tab[bi];
      p1 = tab[bi + 4'h1];
      if (p1 >= p0)
         ip = {5'h00, p0} + (((p1 - p0) * dim[4:0]) >> 5);
      else
         ip = {5'h00, p0} - (((p0 - p1) * dim[4:0]) >> 5);
      if (dim == 8'hff)
         ip = {5'h00, tab[8]};
      cv = ip[7:0];
      if (mode == DCCS_CURVE_GAMMA)
         cv = q.gam;
      adjp = cv * q.adj;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      n = q;
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (psel_i && !penable_i)
      begin
         n.pready = 1'b1;
         n.prdata = 32'h0;
         if (paddr_i[1:0] != 2'h0)
            n.pslverr = 1'b1;
         else if (paddr_i == DCCS_CTRL_OFF)
            n.prdata = {24'h0, q.ctrl};
         else if (paddr_i == DCCS_GAMMA_OFF)
            n.prdata = {23'h0, q.gamma};
         else if (paddr_i == DCCS_ADJ_OFF)
            n.prdata = {23'h0, q.adj};
         else if (paddr_i == DCCS_LOCKVAL_OFF)
            n.prdata = {16'h0, q.lockval};
         else if (paddr_i == DCCS_SLUMVAL_OFF)
            n.prdata = {16'h0, q.slumval};
         else if (paddr_i == DCCS_TIMEA_OFF)
            n.prdata = q.ta;
         else if (paddr_i == DCCS_TIMEB_OFF)
            n.prdata = q.tb;
         else if (paddr_i == DCCS_TIMEC_OFF)
            n.prdata = q.tc;
         else if (paddr_i == DCCS_USR0_OFF)
            n.prdata = q.usr[3:0];
         else if (paddr_i == DCCS_USR1_OFF)
            n.prdata = q.usr[7:4];
         else if (paddr_i == DCCS_USR2_OFF)
            n.prdata = {24'h0, q.usr[8]};
         else if (paddr_i == DCCS_STAT_OFF)
            n.prdata = {13'h0, q.on, q.fading, q.locked, q.volt, dim};
         else if ((paddr_i & DCCS_SCN_MASK) == DCCS_SCN_BASE)
            n.prdata = {14'h0, q.scn_lrn[si], q.scn_en[si], 1'b0, q.scn_num[si],
               q.scn_val[si]};
         else
            n.pslverr = 1'b1;
      end
      if (wr)
      begin
         if (paddr_i == DCCS_CTRL_OFF)
            n.ctrl = pwdata_i[7:0];
         else if (paddr_i == DCCS_GAMMA_OFF)
            n.gamma = (gw < DCCS_GAMMA_MIN) ? DCCS_GAMMA_MIN :
               ((gw > DCCS_GAMMA_MAX) ? DCCS_GAMMA_MAX : gw);
         else if (paddr_i == DCCS_ADJ_OFF)
            n.adj = pwdata_i[8:0];
         else if (paddr_i == DCCS_LOCKVAL_OFF)
            n.lockval = pwdata_i[15:0];
         else if (paddr_i == DCCS_SLUMVAL_OFF)
            n.slumval = pwdata_i[15:0];
         else if (paddr_i == DCCS_TIMEA_OFF)
            n.ta = pwdata_i;
         else if (paddr_i == DCCS_TIMEB_OFF)
            n.tb = pwdata_i;
         else if (paddr_i == DCCS_TIMEC_OFF)
            n.tc = pwdata_i;
         else if (paddr_i == DCCS_USR0_OFF)
            n.usr[3:0] = pwdata_i;
         else if (paddr_i == DCCS_USR1_OFF)
            n.usr[7:4] = pwdata_i;
         else if (paddr_i == DCCS_USR2_OFF)
            n.usr[8] = pwdata_i[7:0];
         else if ((paddr_i & DCCS_SCN_MASK) == DCCS_SCN_BASE)
         begin
            n.scn_val[si] = pwdata_i[7:0];
            n.scn_num[si] = pwdata_i[DCCS_SCN_NUM_LSB +: 7];
            n.scn_en[si] = pwdata_i[DCCS_SCN_EN_BIT];
            n.scn_lrn[si] = pwdata_i[DCCS_SCN_LRN_BIT];
         end
      end

      // Gamma power loop: x^n then x^(n+1), blended by the fraction.
      if (q.gcnt == q.gamma[8:6])
         n.gpa = q.gpw;
      if (q.gcnt == q.gamma[8:6] + 3'h1)
      begin
         n.gpb = q.gpw;
         n.gcnt = 3'h0;
         n.gpw = DCCS_ONE;
         n.gx = (dim == 8'hff) ? DCCS_ONE : d9;
         n.gam = (q.gpa - gdiff[14:6] > 9'h0ff) ? 8'hff : 8'(q.gpa - gdiff[14:6]);
      end
      else
      begin
         n.gpw = gprod[16:8];
         n.gcnt = q.gcnt + 3'h1;
      end

      // Output stage.
      n.volt = (adjp[16:8] > 9'h0ff) ? 8'hff : adjp[15:8];
      n.on = 1'b1;
      if (dim == 8'h00)
      begin
         n.volt = 8'h00;
         n.on = 1'b0;
      end

      // Fade ticks.
      n.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;
      if (q.fading && tick)
      begin
         if (q.pos < tgt_w)
         begin
            if (up_sum >= {1'b0, tgt_w})
            begin
               n.pos = tgt_w;
               n.fading = 1'b0;
            end
            else
               n.pos = up_sum[23:0];
         end
         else if ({1'b0, q.pos} <= {1'b0, tgt_w} + {1'b0, q.step})
         begin
            n.pos = tgt_w;
            n.fading = 1'b0;
         end
         else
            n.pos = q.pos - q.step;
      end

      // Ordinary commands.
      ord_v = 1'b0;
      ord_tgt = 8'h00;
      ord_t = 16'h0;
      if (sw_stb_i)
      begin
         ord_v = 1'b1;
         ord_tgt = sw_val_i ? 8'hff : 8'h00;
      end
      else if (abs_stb_i)
      begin
         ord_v = 1'b1;
         ord_tgt = abs_val_i;
      end
      else if (slumber_stb_i)
      begin
         ord_v = 1'b1;
         ord_tgt = slumber_val_i ? q.slumval[7:0] : q.slumval[15:8];
         if (slumber_val_i)
            ord_t = q.slp_on2 ? q.tb[31:16] : q.tb[15:0];
         else
            ord_t = q.slp_off2 ? q.tc[31:16] : q.tc[15:0];
      end
      else if (scene_stb_i && !scene_cmd_i[7])
      begin
         for (int i = 0; i < 16; i++)
         begin
            if (q.scn_en[i] && q.scn_num[i] == snum)
            begin
               ord_v = 1'b1;
               ord_tgt = q.scn_val[i];
               ord_t = q.ta[15:0];
            end
         end
      end
      go = 1'b0;
      go_tgt = ord_tgt;
      go_t = ord_t;
      if (q.locked)
      begin
         if (ord_v && end_mode == DCCS_END_TRACK)
         begin
            n.trk = ord_tgt;
            n.trk_v = 1'b1;
         end
      end
      else
      begin
         go = ord_v;
         if (ord_v)
         begin
            n.slp_on2 = slumber_stb_i && !sw_stb_i && !abs_stb_i && slumber_val_i;
            n.slp_off2 = slumber_stb_i && !sw_stb_i && !abs_stb_i && !slumber_val_i;
         end
         if (scene_stb_i && scene_cmd_i[7])
         begin
            for (int i = 0; i < 16; i++)
            begin
               if (q.scn_lrn[i] && q.scn_num[i] == snum)
                  n.scn_val[i] = dim;
            end
         end
      end

      // Lock input.
      if (!lock_en)
         n.locked = 1'b0;
      else if (lock_stb_i)
      begin
         if (lock_val_i == q.ctrl[DCCS_LOCK_POL_BIT] && !q.locked)
         begin
            n.locked = 1'b1;
            n.pre = dim;
            n.trk_v = 1'b0;
            if (q.ctrl[DCCS_START_BIT])
            begin
               go = 1'b1;
               go_tgt = q.lockval[7:0];
               go_t = q.ta[31:16];
            end
         end
         else if (lock_val_i != q.ctrl[DCCS_LOCK_POL_BIT] && q.locked)
         begin
            n.locked = 1'b0;
            go_t = q.ta[31:16];
            if (end_mode == DCCS_END_VALUE)
            begin
               go = 1'b1;
               go_tgt = q.lockval[15:8];
            end
            else if (end_mode == DCCS_END_RESTORE)
            begin
               go = 1'b1;
               go_tgt = q.pre;
            end
            else if (end_mode == DCCS_END_TRACK && q.trk_v)
            begin
               go = 1'b1;
               go_tgt = q.trk;
            end
         end
      end

      // Priority inputs, taken with the lock enabled, whether locked or not.
      if (lock_en)
      begin
         if (prio_sw_stb_i)
         begin
            go = 1'b1;
            go_t = 16'h0;
            go_tgt = prio_sw_val_i ? 8'hff : 8'h00;
         end
         else if (prio_rel_stb_i && prio_rel_i[2:0] != 3'h0)
         begin
            go = 1'b1;
            go_t = 16'h0;
            if (prio_rel_i[3])
               go_tgt = (d9 + delta > 9'h0ff) ? 8'hff : 8'(d9 + delta);
            else
               go_tgt = (d9 <= delta) ? 8'h00 : 8'(d9 - delta);
         end
         else if (prio_abs_stb_i)
         begin
            go = 1'b1;
            go_t = 16'h0;
            go_tgt = prio_abs_val_i;
         end
      end

      if (go)
      begin
         n.tgt = go_tgt;
         if (go_t == 16'h0)
         begin
            n.pos = {go_tgt, 16'h0000};
            n.fading = 1'b0;
         end
         else
         begin
            n.step = DCCS_FULL_STEP / {8'h00, go_t};
            n.fading = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         q <= '0;
         q.ctrl <= DCCS_CTRL_RST;
         q.gamma <= DCCS_GAMMA_RST;
         q.adj <= DCCS_ADJ_RST;
         q.gpw <= DCCS_ONE;
      end
      else
         q <= n;
   end

   assign prdata_o = q.prdata;
   assign pready_o = q.pready;
   assign pslverr_o = q.pslverr;
   assign ctrl_volt_o = q.volt;
   assign out_on_o = q.on;
   assign dim_value_o = dim;
   assign locked_o = q.locked;
   assign fading_o = q.fading;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   apb_ready_a: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("APB answer not one cycle after setup.");
   zero_off_a: assert property (dim == 8'h00 |=> !out_on_o && ctrl_volt_o == 8'h00)
      else $error("Output on at zero dimming value.");
   fade_stop_a: assert property ($fell(q.fading) |-> q.pos == {q.tgt, 16'h0000})
      else $error("Fade ended away from its target.");
   lock_block_a: assert property (q.locked && lock_en && ord_v && !lock_stb_i && !prio_any
      |=> q.tgt == $past(q.tgt))
      else $error("Ordinary command acted while locked.");
   lock_engage_a: assert property (lock_en && lock_stb_i && !q.locked
      && lock_val_i == q.ctrl[DCCS_LOCK_POL_BIT] |=> locked_o)
      else $error("Lock did not engage on its polarity.");
   lock_restore_a: assert property (lock_en && lock_stb_i && q.locked && !prio_any
      && lock_val_i != q.ctrl[DCCS_LOCK_POL_BIT] && end_mode == DCCS_END_RESTORE
      |=> !locked_o && q.tgt == $past(q.pre))
      else $error("Release did not restore pre-lock value.");
   prio_abs_a: assert property (lock_en && prio_abs_stb_i && !prio_sw_stb_i && !prio_rel_stb_i
      |=> q.tgt == $past(prio_abs_val_i) && dim == $past(prio_abs_val_i))
      else $error("Priority value not applied.");
   slumber_on_a: assert property (slumber_stb_i && slumber_val_i && !sw_stb_i && !abs_stb_i
      && !q.locked && !lock_stb_i && !prio_any |=> q.tgt == $past(q.slumval[7:0]))
      else $error("Slumber ON target not taken.");
   scene_learn_a: assert property (scene_stb_i && scene_cmd_i[7] && !q.locked
      && q.scn_lrn[0] && q.scn_num[0] == snum |=> q.scn_val[0] == $past(dim))
      else $error("Scene learn did not store present value.");
endmodule
`default_nettype wire

// ---- tb/dccs_ballast.sv ----
// Ballast stage model: lamp level produced from the control voltage.
`timescale 1ns/1ps
`default_nettype none
module dccs_ballast
(
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [7:0] volt_i,
   input wire logic on_i,
   output logic [7:0] lamp_o
);
   typedef struct packed {
      logic [7:0] level;
   } dccs_lamp_type;
   dccs_lamp_type state_q;
   dccs_lamp_type state_d;
   // The lamp is dark whenever the channel is switched off.
   always_comb
   begin
      state_d = state_q;
      state_d.level = on_i ? volt_i : 8'h00;
   end
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end
   assign lamp_o = state_q.level;
endmodule
`default_nettype wire

// ---- tb/dccs_top_test.sv ----
// Self-checking bench for the dimmer channel.
`timescale 1ns/1ps
`default_nettype none
module dccs_top_test;
   import dccs_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] stb = 8'h00;
   logic [7:0] val [0:7] = '{default: 8'h00};
   logic [31:0] prdata;
   logic pready, pslverr, on, locked, fading;
   logic [7:0] volt, dim, lamp;
   logic [31:0] q;
   logic e;
   int err_total = 0;
   int n_checks = 0;
   int cyc = 0;
   always #10 mclk_i = ~mclk_i;
   dccs_top #(.TICK_CYC(4)) u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .paddr_i(paddr),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sw_stb_i(stb[0]), .sw_val_i(val[0][0]),
      .abs_stb_i(stb[1]), .abs_val_i(val[1]), .scene_stb_i(stb[2]), .scene_cmd_i(val[2]),
      .slumber_stb_i(stb[3]), .slumber_val_i(val[3][0]), .lock_stb_i(stb[4]),
      .lock_val_i(val[4][0]), .prio_sw_stb_i(stb[5]), .prio_sw_val_i(val[5][0]),
      .prio_rel_stb_i(stb[6]), .prio_rel_i(val[6][3:0]), .prio_abs_stb_i(stb[7]),
      .prio_abs_val_i(val[7]), .ctrl_volt_o(volt), .out_on_o(on), .dim_value_o(dim),
      .locked_o(locked), .fading_o(fading));
   dccs_ballast u_lamp (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .volt_i(volt), .on_i(on),
      .lamp_o(lamp));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         complete_run();
      end
   end
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_checks++;
      if (got !== ex)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask
   function automatic logic [31:0] cur(input int s);
      case (s)
         0: cur = {24'h0, dim};
         1: cur = {24'h0, volt};
         2: cur = {31'h0, on};
         3: cur = {31'h0, locked};
         4: cur = {31'h0, fading};
         default: cur = {24'h0, lamp};
      endcase
   endfunction
   // Waits a bounded number of cycles for an output to reach a value.
   task automatic exp_in(input string nm, input int s, input logic [31:0] ex, input int n);
      int i;
      i = 0;
      #1;
      while (cur(s) !== ex && i < n)
      begin
         @(posedge mclk_i);
         #1;
         i++;
      end
      chk(nm, ex, cur(s));
   endtask
   task automatic cmd(input int k, input logic [7:0] v);
      @(posedge mclk_i);
      stb[k] <= 1'b1;
      val[k] <= v;
      @(posedge mclk_i);
      stb[k] <= 1'b0;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk_i);
      pen <= 1'b1;
      do
      begin
         @(posedge mclk_i);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk(nm, ex, q);
   endtask
   task automatic t_regs();
      rd("gamma", DCCS_GAMMA_OFF, {23'h0, DCCS_GAMMA_RST});
      rd("adjust", DCCS_ADJ_OFF, {23'h0, DCCS_ADJ_RST});
      rd("unmapped", 8'h30, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, e});
      $display("test regs done");
   endtask
   task automatic t_curve();
      logic [2:0] md [0:2];
      logic [7:0] tb [0:2];
      md = '{DCCS_CURVE_LIN, DCCS_CURVE_LOG, DCCS_CURVE_EXP};
      tb = '{DCCS_LIN_TAB[2], DCCS_LOG_TAB[2], DCCS_EXP_TAB[2]};
      cmd(1, 8'h40);
      for (int c = 0; c < 3; c++)
      begin
         wr(DCCS_CTRL_OFF, {29'h0, md[c]});
         exp_in("curve_volt", 1, {24'h0, tb[c]}, 4);
         exp_in("curve_dim", 0, 32'h40, 1);
      end
      wr(DCCS_CTRL_OFF, 32'h0);
      wr(DCCS_ADJ_OFF, 32'h80);
      exp_in("adj_volt", 1, 32'h20, 4);
      wr(DCCS_ADJ_OFF, 32'h100);
      wr(DCCS_USR0_OFF, 32'h0000_5530);
      wr(DCCS_CTRL_OFF, {29'h0, DCCS_CURVE_USER});
      cmd(1, 8'h10);
      exp_in("user_volt", 1, 32'h42, 4);
      cmd(1, 8'h00);
      exp_in("off_volt", 1, 32'h0, 4);
      exp_in("off_lamp", 5, 32'h0, 4);
      wr(DCCS_GAMMA_OFF, 32'h1ff);
      rd("gamma_clamp", DCCS_GAMMA_OFF, 32'h140);
      wr(DCCS_CTRL_OFF, {29'h0, DCCS_CURVE_GAMMA});
      cmd(1, 8'hff);
      exp_in("gamma_volt", 1, 32'hff, 20);
      wr(DCCS_GAMMA_OFF, 32'h80);
      cmd(1, 8'h80);
      exp_in("gamma_half", 1, 32'h40, 24);
      wr(DCCS_CTRL_OFF, 32'h0);
      $display("test curve done");
   endtask
   task automatic t_scene();
      wr(DCCS_TIMEA_OFF, 32'h2);
      wr(DCCS_SCN_BASE, 32'h0003_0580);
      wr(DCCS_SCN_BASE + 8'h04, 32'h0000_09ee);
      cmd(1, 8'h00);
      cmd(2, 8'h08);
      repeat (3) @(posedge mclk_i);
      exp_in("scene_off", 0, 32'h0, 0);
      cmd(2, 8'h04);
      exp_in("scene_fade", 4, 32'h1, 2);
      exp_in("scene_step", 0, 32'h7f, 6);
      exp_in("scene_end", 0, 32'h80, 6);
      exp_in("scene_done", 4, 32'h0, 2);
      cmd(1, 8'h30);
      cmd(2, 8'h84);
      rd("learned", DCCS_SCN_BASE, 32'h0003_0530);
      $display("test scene done");
   endtask
   task automatic t_slumber();
      wr(DCCS_SLUMVAL_OFF, 32'hc0);
      wr(DCCS_TIMEB_OFF, 32'h0008_0000);
      wr(DCCS_TIMEC_OFF, 32'h0000_0040);
      cmd(1, 8'h00);
      cmd(3, 8'h01);
      exp_in("on1", 0, 32'hc0, 2);
      wr(DCCS_SLUMVAL_OFF, 32'h10);
      cmd(3, 8'h01);
      exp_in("on2_fade", 4, 32'h1, 2);
      exp_in("on2_end", 0, 32'h10, 40);
      cmd(3, 8'h00);
      exp_in("off1_fade", 4, 32'h1, 2);
      cmd(3, 8'h00);
      exp_in("off2", 0, 32'h0, 2);
      $display("test slumber done");
   endtask
   task automatic t_lock();
      wr(DCCS_CTRL_OFF, 32'h98);
      cmd(1, 8'h50);
      cmd(4, 8'h01);
      exp_in("locked", 3, 32'h1, 2);
      cmd(1, 8'h90);
      cmd(2, 8'h04);
      repeat (3) @(posedge mclk_i);
      exp_in("blocked", 0, 32'h50, 0);
      cmd(7, 8'h70);
      exp_in("prio_abs", 0, 32'h70, 2);
      cmd(5, 8'h00);
      exp_in("prio_sw", 0, 32'h0, 2);
      cmd(6, 8'h09);
      exp_in("prio_rel", 0, 32'hff, 2);
      cmd(4, 8'h00);
      exp_in("restore", 0, 32'h50, 4);
      wr(DCCS_CTRL_OFF, 32'hd8);
      cmd(4, 8'h01);
      cmd(1, 8'ha0);
      exp_in("track_hold", 0, 32'h50, 2);
      cmd(4, 8'h00);
      exp_in("track", 0, 32'ha0, 4);
      wr(DCCS_TIMEA_OFF, 32'h0001_0002);
      wr(DCCS_LOCKVAL_OFF, 32'h5533);
      wr(DCCS_CTRL_OFF, 32'h28);
      cmd(4, 8'h00);
      exp_in("pol0", 3, 32'h1, 2);
      exp_in("start_fade", 4, 32'h1, 0);
      exp_in("start_val", 0, 32'h33, 4);
      cmd(4, 8'h01);
      exp_in("unlock", 3, 32'h0, 2);
      exp_in("end_none", 0, 32'h33, 2);
      wr(DCCS_CTRL_OFF, 32'h68);
      cmd(4, 8'h00);
      cmd(4, 8'h01);
      exp_in("end_val", 0, 32'h55, 8);
      $display("test lock done");
   endtask
   initial
   begin
      repeat (4) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_curve();
      t_scene();
      t_slumber();
      t_lock();
      complete_run();
   end
endmodule
`default_nettype wire
